// file: verilog/nibble_swap_xor_subtract_alu.sv
`timescale 1ns/1ps

module nibble_swap_xor_subtract_alu (
	input  wire logic                        i_clk_sys,         // Core clock, 20 MHz.
	input  wire logic                        i_rst,             // Synchronous reset, high.
	input  wire logic                        i_insn_valid,      // Instruction present this cycle.
	input  wire logic [alu_pkg::INSN_W-1:0]  i_insn,            // Instruction word.
	input  wire logic [alu_pkg::DATA_W-1:0]  i_file_rdata,      // Addressed file register.
	output logic      [alu_pkg::FADDR_W-1:0] o_file_addr,       // File register address.
	output logic                             o_file_we,         // File write strobe, one cycle.
	output logic      [alu_pkg::DATA_W-1:0]  o_file_wdata,      // File write data.
	output logic      [alu_pkg::DATA_W-1:0]  o_w,               // Working register.
	output logic                             o_carry_flag,      // Carry flag.
	output logic                             o_digit_carry_flag,// Digit carry flag.
	output logic                             o_zero_flag        // Zero flag.
);
	import alu_pkg::*;

	// ----------------------------------------------------------------
	// Decode.
	// ----------------------------------------------------------------
	op_e                 op;      // Operation class of the current word.
	logic                dest_f;  // High when the result goes to the file.
	logic [DATA_W-1:0]   lit;     // Literal field.

	// Classify the word; the literal subtract ignores its low opcode bit.
	always_comb begin
		op = OP_NONE;
		if (i_insn_valid) begin
			if (i_insn[INSN_W-1:OP6_LSB] == OPC_SWAP) begin
				op = OP_SWAP;
			end else if (i_insn[INSN_W-1:OP6_LSB] == OPC_XORL) begin
				op = OP_XORL;
			end else if (i_insn[INSN_W-1:OP6_LSB] == OPC_SUBF) begin
				op = OP_SUBF;
			end else if (i_insn[INSN_W-1:OP5_LSB] == OPC_SUBL) begin
				op = OP_SUBL;
			end
		end
		dest_f      = i_insn[DEST_BIT] != DEST_W;
		lit         = i_insn[DATA_W-1:0];
		o_file_addr = i_insn[FADDR_W-1:0];
	end

	// ----------------------------------------------------------------
	// Subtractor shared by both subtract operations.
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] sub_a;   // Minuend: literal or file register.
	logic [DATA_W-1:0] sub_d;   // Difference.
	logic              sub_c;   // Inverted borrow.
	logic              sub_dcy; // Inverted nibble borrow.

	// Pick the minuend from the operation.
	always_comb begin
		sub_a = (op == OP_SUBL) ? lit : i_file_rdata;
	end

	alu_sub8 u_sub (
		.i_a      (sub_a),
		.i_b      (o_w),
		.o_diff   (sub_d),
		.o_carry  (sub_c),
		.o_dcarry (sub_dcy)
	);

	// ----------------------------------------------------------------
	// Result and state update.
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] w_r, w_nxt;         // Working register.
	logic              c_r, c_nxt;         // Carry flag.
	logic              dcy_r, dcy_nxt;     // Digit carry flag.
	logic              z_r, z_nxt;         // Zero flag.
	logic              fwe_r, fwe_nxt;     // File write strobe.
	logic [DATA_W-1:0] fwd_r, fwd_nxt;     // File write data.
	logic [DATA_W-1:0] res;                // Result of the current operation.

	// Compute the next state; each operation finishes in its own cycle.
	always_comb begin
		w_nxt   = w_r;
		c_nxt   = c_r;
		dcy_nxt = dcy_r;
		z_nxt   = z_r;
		fwe_nxt = 1'b0;
		fwd_nxt = fwd_r;
		res     = sub_d;
		unique case (op)
			OP_SWAP: begin
				// Nibbles exchanged; flags untouched.
				res = {i_file_rdata[NIB_W-1:0], i_file_rdata[DATA_W-1:NIB_W]};
				if (dest_f) begin
					fwe_nxt = 1'b1;
					fwd_nxt = res;
				end else begin
					w_nxt = res;
				end
			end
			OP_XORL: begin
				// Always to the working register; only zero changes.
				res   = o_w ^ lit;
				w_nxt = res;
				z_nxt = res == '0;
			end
			OP_SUBL: begin
				// Literal minus working register into working register.
				w_nxt  = sub_d;
				c_nxt   = sub_c;
				dcy_nxt = sub_dcy;
				z_nxt   = sub_d == '0;
			end
			OP_SUBF: begin
				// File minus working register to the chosen destination.
				if (dest_f) begin
					fwe_nxt = 1'b1;
					fwd_nxt = sub_d;
				end else begin
					w_nxt = sub_d;
				end
				c_nxt  = sub_c;
				dcy_nxt = sub_dcy;
				z_nxt   = sub_d == '0;
			end
			OP_NONE: begin
				res = sub_d;
			end
		endcase
	end

	// Register the state.
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			w_r   <= W_RST;
			c_r   <= FLAG_RST;
			dcy_r <= FLAG_RST;
			z_r   <= FLAG_RST;
			fwe_r <= 1'b0;
			fwd_r <= W_RST;
		end else begin
			w_r   <= w_nxt;
			c_r   <= c_nxt;
			dcy_r <= dcy_nxt;
			z_r   <= z_nxt;
			fwe_r <= fwe_nxt;
			fwd_r <= fwd_nxt;
		end
	end

	assign o_w                = w_r;
	assign o_carry_flag       = c_r;
	assign o_digit_carry_flag = dcy_r;
	assign o_zero_flag        = z_r;
	assign o_file_we          = fwe_r;
	assign o_file_wdata       = fwd_r;

	// ----------------------------------------------------------------
	// Checks.
	// ----------------------------------------------------------------
	sequence seq_swap_w;
		op == OP_SWAP && !dest_f;
	endsequence

	AST_SWAP_TO_W: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		seq_swap_w |=> o_w == {$past(i_file_rdata[3:0]), $past(i_file_rdata[7:4])})
		else $error("swap to working register wrong");

	AST_SWAP_TO_F: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		op == OP_SWAP && dest_f |=> o_file_we
			&& o_file_wdata == {$past(i_file_rdata[3:0]), $past(i_file_rdata[7:4])}
			&& $stable(o_w))
		else $error("swap to file wrong");

	AST_SWAP_FLAGS: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		op == OP_SWAP |=> $stable(o_carry_flag) && $stable(o_digit_carry_flag)
			&& $stable(o_zero_flag))
		else $error("swap changed a flag");

	AST_XOR_VALUE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		op == OP_XORL |=> o_w == ($past(o_w) ^ $past(i_insn[7:0])) && !o_file_we)
		else $error("xor literal result wrong");

	AST_XOR_FLAGS: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		op == OP_XORL |=> $stable(o_carry_flag) && $stable(o_digit_carry_flag)
			&& o_zero_flag == (o_w == 8'h00))
		else $error("xor literal flags wrong");

	// The minuend is taken straight from the word or the file, not from the shared mux.
	AST_SUB_BORROW: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(op == OP_SUBL && i_insn[DATA_W-1:0] < o_w)
			|| (op == OP_SUBF && i_file_rdata < o_w) |=> !o_carry_flag)
		else $error("negative difference left carry set");

	AST_SUB_NOBORROW: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(op == OP_SUBL && i_insn[DATA_W-1:0] >= o_w)
			|| (op == OP_SUBF && i_file_rdata >= o_w) |=> o_carry_flag)
		else $error("non-negative difference cleared carry");

	AST_SUBL_VALUE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		op == OP_SUBL |=> o_w == 8'($past(i_insn[7:0]) - $past(o_w))
			&& o_zero_flag == (o_w == 8'h00))
		else $error("literal subtract wrong");

	AST_SUBF_VALUE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		op == OP_SUBF && dest_f |=> o_file_we
			&& o_file_wdata == 8'($past(i_file_rdata) - $past(o_w)) && $stable(o_w))
		else $error("file subtract wrong");

	// Either subtract operation is taken this cycle.
	sequence seq_sub_any;
		op == OP_SUBL || op == OP_SUBF;
	endsequence

	AST_SUBF_TO_W: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		op == OP_SUBF && !dest_f |=> !o_file_we
			&& o_w == DATA_W'($past(i_file_rdata) - $past(o_w)))
		else $error("file subtract into working register wrong");

	AST_SUB_DIGIT: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		seq_sub_any |=> o_digit_carry_flag == $past((op == OP_SUBL ? i_insn[NIB_W-1:0]
			: i_file_rdata[NIB_W-1:0]) >= o_w[NIB_W-1:0]))
		else $error("digit carry after subtract wrong");

	AST_SUB_ZERO: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		seq_sub_any |=> o_zero_flag == $past((op == OP_SUBL ? i_insn[DATA_W-1:0]
			: i_file_rdata) == o_w))
		else $error("zero flag after subtract wrong");

endmodule : nibble_swap_xor_subtract_alu

// file: verilog/alu_pkg.sv
package alu_pkg;

	// ----------------------------------------------------------------
	// Instruction word layout.
	// ----------------------------------------------------------------
	localparam int unsigned INSN_W    = 14;  // Width of one instruction word.
	localparam int unsigned DATA_W    = 8;   // Width of the data path.
	localparam int unsigned FADDR_W   = 7;   // Width of a file register address.
	localparam int unsigned NIB_W     = 4;   // Width of one nibble.
	localparam int unsigned DEST_BIT  = 7;   // Position of the destination-select bit.
	localparam int unsigned OP6_LSB   = 8;   // Low bit of the six-bit opcode field.
	localparam int unsigned OP5_LSB   = 9;   // Low bit of the five-bit opcode field.

	// ----------------------------------------------------------------
	// Opcode patterns.
	// ----------------------------------------------------------------
	localparam logic [5:0] OPC_SWAP   = 6'h0E;  // 00 1110 dfff ffff.
	localparam logic [5:0] OPC_XORL   = 6'h3A;  // 11 1010 kkkk kkkk.
	localparam logic [5:0] OPC_SUBF   = 6'h02;  // 00 0010 dfff ffff.
	localparam logic [4:0] OPC_SUBL   = 5'h1E;  // 11 110x kkkk kkkk.

	// ----------------------------------------------------------------
	// Destination select and reset values.
	// ----------------------------------------------------------------
	localparam logic       DEST_W     = 1'b0;   // Result goes to the working register.
	localparam logic [7:0] W_RST      = 8'h00;  // Working register after reset.
	localparam logic       FLAG_RST   = 1'b0;   // Status flags after reset.

	// Operation classes recognised by the decoder.
	typedef enum logic [2:0] {
		OP_NONE,
		OP_SWAP,
		OP_XORL,
		OP_SUBL,
		OP_SUBF
	} op_e;

endpackage : alu_pkg

// file: verilog/alu_sub8.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Eight-bit subtractor: minuend minus subtrahend with inverted borrows.
// ----------------------------------------------------------------
module alu_sub8 (
	input  wire logic [alu_pkg::DATA_W-1:0] i_a,        // Minuend.
	input  wire logic [alu_pkg::DATA_W-1:0] i_b,        // Subtrahend.
	output logic      [alu_pkg::DATA_W-1:0] o_diff,     // Difference modulo 256.
	output logic                            o_carry,    // High when no borrow.
	output logic                            o_dcarry    // High when no low-nibble borrow.
);
	import alu_pkg::*;

	logic [DATA_W:0] full;  // Nine-bit sum of a plus the complement of b plus one.
	logic [NIB_W:0]  low;   // Five-bit sum on the low nibble alone.

	// Two's complement subtraction; the top bit is the inverted borrow.
	always_comb begin
		full     = {1'b0, i_a} + {1'b0, ~i_b} + {{DATA_W{1'b0}}, 1'b1};
		low      = {1'b0, i_a[NIB_W-1:0]} + {1'b0, ~i_b[NIB_W-1:0]} + {{NIB_W{1'b0}}, 1'b1};
		o_diff   = full[DATA_W-1:0];
		o_carry  = full[DATA_W];
		o_dcarry = low[NIB_W];
	end

endmodule : alu_sub8

// file: test/file_reg_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// File register array seen by the datapath.
// ----------------------------------------------------------------
module file_reg_model (
	input  wire logic       i_clk_sys,  // Core clock.
	input  wire logic [6:0] i_addr,     // Read address, follows the instruction.
	input  wire logic       i_we,       // Write strobe, one cycle late.
	input  wire logic [7:0] i_wdata,    // Write data.
	input  wire logic       i_pre_we,   // Preload strobe from the bench.
	input  wire logic [6:0] i_pre_addr, // Preload address.
	input  wire logic [7:0] i_pre_data, // Preload data.
	output logic      [7:0] o_rdata     // Read data, combinational.
);
	logic [7:0] mem [128];  // Register contents.
	logic [6:0] addr_r;     // Address of the instruction just taken.

	// Reads are combinational from the current address.
	assign o_rdata = mem[i_addr];

	// The strobe comes a cycle after the instruction, so the write uses the held address.
	always_ff @(posedge i_clk_sys) begin
		addr_r <= i_addr;
		// Preloads come only while the datapath writes nothing, so one process owns the array.
		if (i_pre_we) begin
			mem[i_pre_addr] <= i_pre_data;
		end else if (i_we) begin
			mem[addr_r] <= i_wdata;
		end
	end
endmodule : file_reg_model

// file: test/nibble_swap_xor_subtract_alu_tb_top.sv
`timescale 1ns/1ps

module nibble_swap_xor_subtract_alu_tb_top;
	import alu_pkg::*;
	logic       clk = 1'b0;     // Core clock.
	logic       rst = 1'b1;     // Reset.
	logic       vld = 1'b0;     // Instruction valid.
	logic [13:0] insn = 14'h0000; // Instruction word.
	logic [7:0] rdata;          // File read data.
	logic [6:0] addr;           // File address.
	logic       we;             // File write strobe.
	logic [7:0] wdata;          // File write data.
	logic [7:0] w;              // Working register.
	logic       c, dcf, z;      // Status flags.
	logic       pre_we = 1'b0;  // Model preload strobe.
	logic [6:0] pre_addr = 7'h00; // Model preload address.
	logic [7:0] pre_data = 8'h00; // Model preload data.
	int         failures = 0;
	int         samples_checked = 0;

	// ----------------------------------------------------------------
	// Clock, device and partner.
	// ----------------------------------------------------------------
	always #25 clk = ~clk;

	nibble_swap_xor_subtract_alu u_nibble_swap_xor_subtract_alu (.i_clk_sys(clk),
		.i_rst(rst), .i_insn_valid(vld), .i_insn(insn), .i_file_rdata(rdata),
		.o_file_addr(addr), .o_file_we(we), .o_file_wdata(wdata), .o_w(w),
		.o_carry_flag(c), .o_digit_carry_flag(dcf), .o_zero_flag(z));

	file_reg_model u_file_reg_model (.i_clk_sys(clk), .i_addr(addr), .i_we(we),
		.i_wdata(wdata), .i_pre_we(pre_we), .i_pre_addr(pre_addr),
		.i_pre_data(pre_data), .o_rdata(rdata));

	// ----------------------------------------------------------------
	// Shared tasks.
	// ----------------------------------------------------------------
	// Compares a seen value with the expected one.
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// Writes one file register through the model's preload port.
	task automatic preload(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk);
		pre_we   <= 1'b1;
		pre_addr <= a;
		pre_data <= d;
		@(posedge clk);
		pre_we   <= 1'b0;
	endtask : preload

	// Presents one instruction for one cycle and waits until its result shows.
	task automatic run(input logic [13:0] i, input logic v = 1'b1);
		@(posedge clk);
		insn <= i;
		vld  <= v;
		@(posedge clk);
		vld  <= 1'b0;
		#1;
	endtask : run

	// Checks W, the flags packed as C DC Z, and the write strobe with its data.
	task automatic expect_all(input logic [7:0] ew, input logic [2:0] ef, input logic ewe,
		input logic [7:0] ed);
		chk(w, ew);
		chk({5'h00, c, dcf, z}, {5'h00, ef});
		chk({7'h00, we}, {7'h00, ewe});
		if (ewe) begin
			chk(wdata, ed);
		end
	endtask : expect_all

	// ----------------------------------------------------------------
	// Scenarios.
	// ----------------------------------------------------------------
	// Literal 2 minus W for W of 3, 2 and 1, both opcode variants; then carry and
	// digit carry apart from each other.
	task automatic test_subl;
		run(14'h3A03);
		run(14'h3C02);
		expect_all(8'hFF, 3'b000, 1'b0, 8'h00);
		run(14'h3AFD);
		run(14'h3D02);
		expect_all(8'h00, 3'b111, 1'b0, 8'h00);
		run(14'h3A01);
		run(14'h3C02);
		expect_all(8'h01, 3'b110, 1'b0, 8'h00);
		run(14'h3C10);
		expect_all(8'h0F, 3'b100, 1'b0, 8'h00);
		run(14'h3A1F);
		run(14'h3C01);
		expect_all(8'hF1, 3'b010, 1'b0, 8'h00);
		run(14'h3CF2);
		expect_all(8'h01, 3'b110, 1'b0, 8'h00);
	endtask : test_subl

	// Xor changes W and Z only; literal bit 7 never selects the file.
	task automatic test_xorl;
		run(14'h3AB4);
		expect_all(8'hB5, 3'b110, 1'b0, 8'h00);
		run(14'h3AAF);
		expect_all(8'h1A, 3'b110, 1'b0, 8'h00);
		run(14'h3A1A);
		expect_all(8'h00, 3'b111, 1'b0, 8'h00);
	endtask : test_xorl

	// File minus W into the file, then into W.
	task automatic test_subf;
		preload(7'h05, 8'h01);
		preload(7'h06, 8'h03);
		run(14'h3A02);
		run(14'h0285);
		expect_all(8'h02, 3'b000, 1'b1, 8'hFF);
		run(14'h0206);
		expect_all(8'h01, 3'b110, 1'b0, 8'h00);
		chk(u_file_reg_model.mem[5], 8'hFF);
	endtask : test_subf

	// Swap into W, then into the file, flags untouched.
	task automatic test_swap;
		preload(7'h07, 8'hA5);
		run(14'h0E07);
		expect_all(8'h5A, 3'b110, 1'b0, 8'h00);
		run(14'h0E87);
		expect_all(8'h5A, 3'b110, 1'b1, 8'h5A);
		chk({1'b0, addr}, 8'h07);
	endtask : test_swap

	// Unknown opcodes and invalid cycles change nothing.
	task automatic test_refused;
		run(14'h06AF);
		expect_all(8'h5A, 3'b110, 1'b0, 8'h00);
		run(14'h3AFF, 1'b0);
		run(14'h0E87, 1'b0);
		expect_all(8'h5A, 3'b110, 1'b0, 8'h00);
		chk(u_file_reg_model.mem[7], 8'h5A);
	endtask : test_refused

	// ----------------------------------------------------------------
	// Verdict.
	// ----------------------------------------------------------------
	task automatic tally_and_finish;
		if (failures == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : tally_and_finish

	// Main sequence.
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		test_subl();
		test_xorl();
		test_subf();
		test_swap();
		test_refused();
		tally_and_finish();
	end

	// Cuts a hang short well beyond the few dozen cycles the tests need.
	initial begin
		#100000;
		failures++;
		tally_and_finish();
	end
endmodule : nibble_swap_xor_subtract_alu_tb_top
